// ===== verilog/ccti_top.sv
`timescale 1ns/1ns
module ccti_top
  import ccti_pkg::*;
#(
  parameter int WAIT_STEP_CYC = WAIT_STEP_CYCLES
)(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        special_valid_i,
  input  wire logic [4:0]  special_code_i,
  input  wire logic        cycle_done_i,
  input  wire logic [15:0] clear_result_i,
  input  wire logic        wait_start_i,
  output logic             wait_busy_o,
  output logic             wait_done_o,
  output logic      [1:0]  analog_gain_code_o,
  output logic             irq_pin_o,
  output logic             irq_pin_oe_o
);
  logic [7:0]  low_thresh_lsb;
  logic [7:0]  low_thresh_msb;
  logic [7:0]  high_thresh_lsb;
  logic [7:0]  high_thresh_msb;
  logic [3:0]  consecutive_outside_count;
  logic        wait_times_twelve;
  logic [7:0]  wait_period_byte;
  logic        threshold_irq_enable;
  logic        threshold_irq_pending;
  logic        irq_clear;
  logic        irq_set;
  logic [7:0]  next_rdata;
  logic [11:0] wait_steps;
  logic [11:0] steps_left;
  logic [17:0] step_cnt;
  ccti_wait_state_t wait_state;

  ccti_filt_if filt ();

  // Writable configuration; reserved bits are simply not stored.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      low_thresh_lsb            <= RESET_BYTE;
      low_thresh_msb            <= RESET_BYTE;
      high_thresh_lsb           <= RESET_BYTE;
      high_thresh_msb           <= RESET_BYTE;
      consecutive_outside_count <= RESET_BYTE[3:0];
      wait_times_twelve         <= 1'b0;
      wait_period_byte          <= RESET_BYTE;
      threshold_irq_enable      <= 1'b0;
      analog_gain_code_o        <= RESET_BYTE[1:0];
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_LOW_LSB:  low_thresh_lsb <= reg_wdata_i;
        ADDR_LOW_MSB:  low_thresh_msb <= reg_wdata_i;
        ADDR_HIGH_LSB: high_thresh_lsb <= reg_wdata_i;
        ADDR_HIGH_MSB: high_thresh_msb <= reg_wdata_i;
        ADDR_FILTER:
          consecutive_outside_count <= reg_wdata_i[3:0];
        ADDR_WAIT_CFG:
          wait_times_twelve <= reg_wdata_i[BIT_WAIT_LONG];
        ADDR_WAIT:     wait_period_byte <= reg_wdata_i;
        ADDR_ENABLE:
          threshold_irq_enable <= reg_wdata_i[BIT_IRQ_EN];
        ADDR_GAIN:
          analog_gain_code_o <= reg_wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // Hand the thresholds and the filter code to the persistence filter.
  assign filt.eval        = cycle_done_i;
  assign filt.clear_value = clear_result_i;
  assign filt.low_thresh  = {low_thresh_msb, low_thresh_lsb};
  assign filt.high_thresh = {high_thresh_msb, high_thresh_lsb};
  assign filt.irq_filter_count_code   = consecutive_outside_count;

  ccti_persist u_persist (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .f         (filt.filter)
  );

  // Pending flag; a new event in the clear cycle wins so none is lost.
  assign irq_clear = special_valid_i &&
                     special_code_i == SF_IRQ_CLEAR;
  assign irq_set   = filt.fire && threshold_irq_enable;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      threshold_irq_pending <= 1'b0;
    end else if (irq_set) begin
      threshold_irq_pending <= 1'b1;
    end else if (irq_clear) begin
      threshold_irq_pending <= 1'b0;
    end
  end

  // Open-drain pin: drive low while an interrupt is pending.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_o <= 1'b0;
    end else begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_o <= threshold_irq_pending || irq_set;
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero.
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      ADDR_ENABLE:   next_rdata[BIT_IRQ_EN] = threshold_irq_enable;
      ADDR_WAIT:     next_rdata = wait_period_byte;
      ADDR_LOW_LSB:  next_rdata = low_thresh_lsb;
      ADDR_LOW_MSB:  next_rdata = low_thresh_msb;
      ADDR_HIGH_LSB: next_rdata = high_thresh_lsb;
      ADDR_HIGH_MSB: next_rdata = high_thresh_msb;
      ADDR_FILTER:   next_rdata[3:0] = consecutive_outside_count;
      ADDR_WAIT_CFG: next_rdata[BIT_WAIT_LONG] = wait_times_twelve;
      ADDR_GAIN:     next_rdata[1:0] = analog_gain_code_o;
      ADDR_STATUS:
        next_rdata[BIT_IRQ_PEND] = threshold_irq_pending;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Two's-complement byte gives 256 minus value steps, times twelve if long.
  assign wait_steps = wait_times_twelve ?
    12'(12'(WAIT_BASE - 9'(wait_period_byte)) * WAIT_LONG_MUL) :
    12'(WAIT_BASE - 9'(wait_period_byte));

  // Wait timer; a start while busy is ignored to keep the period whole.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wait_state  <= CCTI_IDLE;
      steps_left  <= 12'h000;
      step_cnt    <= 18'h00000;
      wait_busy_o <= 1'b0;
      wait_done_o <= 1'b0;
    end else begin
      wait_done_o <= 1'b0;
      case (wait_state)
        CCTI_IDLE: begin
          if (wait_start_i) begin
            wait_state  <= CCTI_RUN;
            steps_left  <= wait_steps;
            step_cnt    <= 18'h00000;
            wait_busy_o <= 1'b1;
          end
        end
        CCTI_RUN: begin
          if (step_cnt == 18'(WAIT_STEP_CYC - 1)) begin
            step_cnt   <= 18'h00000;
            steps_left <= steps_left - 12'h001;
            if (steps_left == 12'h001) begin
              wait_state  <= CCTI_IDLE;
              wait_busy_o <= 1'b0;
              wait_done_o <= 1'b1;
            end
          end else begin
            step_cnt <= step_cnt + 18'h00001;
          end
        end
        default: wait_state <= CCTI_IDLE;
      endcase
    end
  end

  a_pend_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    filt.fire && threshold_irq_enable |=> threshold_irq_pending
    ##1 irq_pin_oe_o)
    else $error("Enabled fire did not set the pending flag.");
  a_pend_disabled: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !threshold_irq_pending && !(filt.fire && threshold_irq_enable)
    |=> !threshold_irq_pending)
    else $error("Pending flag rose without an enabled event.");
  a_pend_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq_clear && !irq_set |=> !threshold_irq_pending)
    else $error("Clear command left the interrupt pending.");
  a_pend_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    threshold_irq_pending && !irq_clear |=> threshold_irq_pending)
    else $error("Pending interrupt dropped without a clear command.");
  a_status_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_addr_i == 5'h13 |=> reg_rdata_o == {3'h0,
    $past(threshold_irq_pending), 4'h0})
    else $error("Status read does not show the pending flag.");
  a_gain_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == 5'h0F |=>
    analog_gain_code_o == $past(reg_wdata_i[1:0]))
    else $error("Gain code did not take the written value.");
  a_wait_long: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wait_state == CCTI_IDLE && wait_start_i && wait_times_twelve &&
    wait_period_byte == 8'hFF |=> steps_left == 12'h00C)
    else $error("Long wait of one step did not give twelve steps.");
endmodule

// ===== verilog/ccti_pkg.sv
// Operation
// - Compare clear result against both thresholds.
// - Low threshold bytes at 0x04 and 0x05.
// - High threshold bytes at 0x06 and 0x07.
// - Persistence code in bits 3:0 of 0x0C.
// - Code 0000 fires every integration cycle.
// - Code 0001 fires on one outside result.
// - Codes 0010, 0011 need two, three consecutive.
// - Codes 0100 to 1111 need 5 to 60.
// - Config bit 1 stretches wait twelvefold.
// - Gain code in bits 1:0 of 0x0F.
// - Interrupt only while enable bit 4 set.
// - Pending interrupt holds until clear command 00110.
// - Status bit 4 shows pending interrupt.
// - Wait counted in 2.4 ms steps.
package ccti_pkg;
  localparam logic [4:0] ADDR_ENABLE    = 5'h00;
  localparam logic [4:0] ADDR_WAIT      = 5'h03;
  localparam logic [4:0] ADDR_LOW_LSB   = 5'h04;
  localparam logic [4:0] ADDR_LOW_MSB   = 5'h05;
  localparam logic [4:0] ADDR_HIGH_LSB  = 5'h06;
  localparam logic [4:0] ADDR_HIGH_MSB  = 5'h07;
  localparam logic [4:0] ADDR_FILTER    = 5'h0C;
  localparam logic [4:0] ADDR_WAIT_CFG  = 5'h0D;
  localparam logic [4:0] ADDR_GAIN      = 5'h0F;
  localparam logic [4:0] ADDR_STATUS    = 5'h13;
  localparam int         BIT_IRQ_EN     = 4;
  localparam int         BIT_IRQ_PEND   = 4;
  localparam int         BIT_WAIT_LONG  = 1;
  localparam logic [4:0] SF_IRQ_CLEAR   = 5'h06;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [3:0] IRQ_FILTER_COUNT_EVERY     = 4'h0;
  localparam logic [3:0] IRQ_FILTER_COUNT_LINEAR    = 4'h3;
  localparam logic [5:0] IRQ_FILTER_COUNT_STEP      = 6'h05;
  localparam logic [5:0] CNT_MAX        = 6'h3F;
  localparam logic [11:0] WAIT_LONG_MUL = 12'h00C;
  localparam logic [8:0] WAIT_BASE      = 9'h100;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         WAIT_STEP_NS   = 2400000;
  localparam int         WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
  typedef enum logic {CCTI_IDLE, CCTI_RUN} ccti_wait_state_t;
endpackage

// ===== verilog/ccti_filt_if.sv
`timescale 1ns/1ns
// Signals between the register block and the persistence filter.
interface ccti_filt_if;
  logic        eval;
  logic [15:0] clear_value;
  logic [15:0] low_thresh;
  logic [15:0] high_thresh;
  logic [3:0]  irq_filter_count_code;
  logic        fire;
  modport owner  (output eval, clear_value, low_thresh, high_thresh,
                  irq_filter_count_code, input fire);
  modport filter (input eval, clear_value, low_thresh, high_thresh,
                  irq_filter_count_code, output fire);
endinterface

// ===== verilog/ccti_persist.sv
`timescale 1ns/1ns
module ccti_persist
  import ccti_pkg::*;
(
  input  wire logic     ref_clk_i,
  input  wire logic     reset_i,
  ccti_filt_if.filter   f
);
  logic [5:0] outside_cnt;
  logic [5:0] next_outside_cnt;
  logic       outside;
  logic       fire;

  // Consecutive outside results needed for a given filter code.
  function automatic logic [5:0] required_count(input logic [3:0] code);
    logic [5:0] steps;
    steps = 6'(code) - 6'(IRQ_FILTER_COUNT_LINEAR);
    if (code <= IRQ_FILTER_COUNT_LINEAR) begin
      required_count = 6'(code);
    end else begin
      required_count = 6'(steps * IRQ_FILTER_COUNT_STEP);
    end
  endfunction

  // Outside means strictly below low or strictly above high.
  assign outside = (f.clear_value < f.low_thresh) ||
                   (f.clear_value > f.high_thresh);
  // The counter saturates so a long run never wraps back to zero.
  assign next_outside_cnt = outside ?
    ((outside_cnt == CNT_MAX) ? outside_cnt : outside_cnt + 6'h01) :
    6'h00;

  // Counter moves only on a finished integration.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      outside_cnt <= 6'h00;
    end else if (f.eval) begin
      outside_cnt <= next_outside_cnt;
    end
  end

  // Fire decision, one cycle after the evaluation strobe.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fire <= 1'b0;
    end else begin
      fire <= f.eval && ((f.irq_filter_count_code == IRQ_FILTER_COUNT_EVERY) ||
              (outside && next_outside_cnt >= required_count(f.irq_filter_count_code)));
    end
  end
  assign f.fire = fire;

  a_every_cycle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    f.eval && f.irq_filter_count_code == 4'h0 |=> fire)
    else $error("Code zero did not fire after an integration.");
  a_single_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    f.eval && f.irq_filter_count_code == 4'h1 && outside |=> fire)
    else $error("Single outside result did not fire.");
  a_inrange_reset: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    f.eval && !outside |=> outside_cnt == 6'h00 && $past(f.irq_filter_count_code) == 4'h0
    || outside_cnt == 6'h00 && !fire)
    else $error("In-range result did not reset the run.");
  a_quiet_between: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !f.eval |=> !fire && $stable(outside_cnt))
    else $error("Filter changed without an integration.");
  a_run_of_five: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    f.eval && f.irq_filter_count_code == 4'h4 && outside && outside_cnt == 6'h03
    |=> !fire)
    else $error("Code 0100 fired after only four results.");
endmodule

// ===== dv/ccti_host_model.sv
`timescale 1ns/1ns
// Host side of the register port and the special-function command path.
module ccti_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [4:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            special_valid_o,
  output logic      [4:0] special_code_o
);
  localparam logic [4:0] SF_CODE = 5'h06;

  // Idle values at time zero, before reset is released.
  initial begin
    reg_addr_o = 5'h1F;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    special_valid_o = 1'b0;
    special_code_o = 5'h00;
  end

  // Callers pass data with reserved bits already zero; released data is
  // inverted so a stale byte can never be taken by mistake.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wr_o <= 1'b1;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask

  // Read data follows the address by one edge.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    #1;
    d = reg_rdata_i;
  endtask

  // The clear command is a single strobe; nothing is needed to undo it.
  task automatic clr();
    @(posedge ref_clk_i);
    special_valid_o <= 1'b1;
    special_code_o <= SF_CODE;
    @(posedge ref_clk_i);
    special_valid_o <= 1'b0;
    special_code_o <= ~SF_CODE;
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ccti_pkg::*;
  localparam int STEP = 4;
  logic        ref_clk_i, reset_i, cycle_done_i, wait_start_i;
  logic [15:0] clear_result_i;
  logic [4:0]  reg_addr, special_code;
  logic        reg_wr, special_valid;
  logic [7:0]  reg_wdata, reg_rdata_o;
  logic        wait_busy_o, wait_done_o, irq_pin_o, irq_pin_oe_o;
  logic [1:0]  analog_gain_code_o;
  int          miscompares = 0, tests_run = 0, seed = 3, r, lo, hi, cnt;
  int          code, n, v;
  bit          en, pend;
  logic [7:0]  d;
  logic [4:0]  addrs [8] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h07, 5'h0C,
                             5'h0D, 5'h0F};
  logic [7:0]  masks [8] = '{8'h10, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
                             8'h02, 8'h03};

  ccti_top #(.WAIT_STEP_CYC(STEP)) dut (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
    .special_valid_i(special_valid), .special_code_i(special_code),
    .cycle_done_i(cycle_done_i), .clear_result_i(clear_result_i),
    .wait_start_i(wait_start_i), .wait_busy_o(wait_busy_o),
    .wait_done_o(wait_done_o), .analog_gain_code_o(analog_gain_code_o),
    .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));
  ccti_host_model host (.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata),
    .special_valid_o(special_valid), .special_code_o(special_code));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Results a filter code must see in an unbroken run.
  function automatic int need(input int c);
    return (c <= 3) ? c : 5 * (c - 3);
  endfunction

  task automatic thr(input logic [15:0] l, input logic [15:0] h);
    lo = l;
    hi = h;
    host.wr(ADDR_LOW_LSB, l[7:0]);
    host.wr(ADDR_LOW_MSB, l[15:8]);
    host.wr(ADDR_HIGH_LSB, h[7:0]);
    host.wr(ADDR_HIGH_MSB, h[15:8]);
  endtask

  // One integration result; the model decides the pin, then any pending
  // interrupt is polled and cleared so each result is judged alone.
  task automatic meas(input logic [15:0] val);
    logic [7:0] s;
    @(posedge ref_clk_i);
    cycle_done_i <= 1'b1;
    clear_result_i <= val;
    @(posedge ref_clk_i);
    cycle_done_i <= 1'b0;
    clear_result_i <= ~val;
    if (val < lo || val > hi) cnt = (cnt < 63) ? cnt + 1 : 63;
    else cnt = 0;
    if (en && (code == 0 || cnt >= need(code))) pend = 1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(irq_pin_oe_o, pend);
    if (pend) begin
      host.rd(ADDR_STATUS, s);
      chk(s[4], 1'b1);
      chk(irq_pin_o, 1'b0);
      host.clr();
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk(irq_pin_oe_o, 1'b0);
      pend = 0;
    end
  endtask

  // Wait timer length in base steps, with the twelvefold stretch.
  task automatic wt(input logic [7:0] b, input logic lng);
    int k;
    host.wr(ADDR_WAIT, b);
    host.wr(ADDR_WAIT_CFG, {6'h00, lng, 1'b0});
    @(posedge ref_clk_i);
    wait_start_i <= 1'b1;
    @(posedge ref_clk_i);
    wait_start_i <= 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      #1;
      k++;
      if (k == 1) chk(wait_busy_o, 1'b1);
    end while (wait_done_o !== 1'b1 && k < 5000);
    chk(k, (256 - b) * (lng ? 12 : 1) * STEP);
    $display("test wait %h long %0d done", b, lng);
  endtask

  // A hang counts as a mismatch.
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    miscompares++;
    test_done();
  end

  initial begin
    reset_i = 1'b1;
    cycle_done_i = 1'b0;
    clear_result_i = 16'h0000;
    wait_start_i = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      host.rd(addrs[i], d);
      chk(d, 8'h00);
    end
    host.rd(5'h1F, d);
    chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      host.wr(addrs[i], r[7:0] & masks[i]);
      host.rd(addrs[i], d);
      chk(d, r[7:0] & masks[i]);
    end
    for (int g = 0; g < 4; g++) begin
      host.wr(ADDR_GAIN, g[7:0]);
      host.rd(ADDR_GAIN, d);
      chk(analog_gain_code_o, g[1:0]);
    end
    $display("test registers done");
    // With the enable bit low an outside result is dropped.
    host.wr(ADDR_ENABLE, 8'h00);
    en = 0;
    pend = 0;
    cnt = 0;
    code = 1;
    thr(16'h1000, 16'h2000);
    host.wr(ADDR_FILTER, 8'h01);
    meas(16'h3000);
    host.wr(ADDR_ENABLE, 8'h10);
    en = 1;
    $display("test enable done");
    for (int c = 0; c < 16; c++) begin
      r = $random(seed);
      thr(16'h0100 + r[11:0], 16'h8000 + r[25:12]);
      code = c;
      host.wr(ADDR_FILTER, {4'h0, c[3:0]});
      meas(lo);
      n = need(c) * 2 + 2;
      for (int i = 0; i < n; i++) begin
        r = $random(seed);
        if (i == need(c) / 2) v = c[0] ? lo : hi;
        else if (r[0]) v = r[31:16] % lo;
        else v = hi + 1 + (r[31:16] % (65535 - hi));
        meas(v);
      end
      $display("test filter code %0d done", c);
    end
    wt(8'hFF, 1'b0);
    wt(8'hFE, 1'b0);
    wt(8'hFE, 1'b1);
    test_done();
  end
endmodule
